// ==== dbsi_params.svh ====
// Constants for the burst-of-two SRAM interface
`ifndef DBSI_PARAMS_SVH
`define DBSI_PARAMS_SVH
`define DBSI_CLK_PERIOD_NS 10
`define DBSI_CAL_INTERVAL_NS 20480
`define DBSI_CAL_CYCLES ((`DBSI_CAL_INTERVAL_NS) / (`DBSI_CLK_PERIOD_NS))
`define DBSI_CAL_CNT_W 12
`define DBSI_CODE_W 4
`define DBSI_CODE_RESET 4'h8
`define DBSI_CODE_MAX 4'hF
`define DBSI_CODE_MIN 4'h0
`endif

// ==== dbsi_pkg.sv ====
// Types for the burst-of-two SRAM interface
package dbsi_pkg;
	typedef enum logic [1:0] {
		DBSI_NOP = 2'b00,
		DBSI_READ = 2'b01,
		DBSI_WRITE = 2'b10
	} dbsi_cmd_t;
endpackage

// ==== dbsi_sram.sv ====
// Burst-of-two common-I/O DDR SRAM core with impedance calibration
// Functional notes
// - Every accepted read or write moves exactly two beats, on K then K-bar.
// - Deselect after read runs the read pipeline, finishes the read, then releases DQ.
// - Load high ignores read/write select; device deselects after outstanding bursts.
// - Address, load and select sampled on K rise; load low, select high reads unless the two-entry read buffer is full.
// - Read captured at edge n drives first beat at n+2, done by n+3.
// - Second write beat captured on the K-bar rise right after beat one.
// - Byte enables sampled with each beat; high enable keeps stored byte intact.
// - Any lane of either beat may be masked independently.
// - Each write address is the base of a two-beat, double-width store.
// - Narrow variant uses four-bit nybble enables with the same behaviour.
// - Free-running cycle counter periodically starts impedance evaluation, then restarts.
// - Each evaluation moves the driver code at most one step toward optimum.
// - Termination always on; select low strong range, high weak range.
// - Termination impedance recalibrated by the same counter-driven stepping.
// - Non-read commands disable DQ drivers for one cycle in the read slot.
// - While drivers are off the pin level comes from input termination.
// - Nybble enable 0 gates data bits 3..0, enable 1 bits 7..4.
`timescale 1ns/1ps
`default_nettype none
`include "dbsi_params.svh"

module dbsi_buf2 #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] slot [0:1];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;

	assign in_ready = (count != 2'd2);
	assign out_valid = (count != 2'd0);
	assign out_data = slot[rd_ptr];

	always_ff @(posedge ref_clk) begin
		if (ce && in_valid && in_ready) begin
			slot[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
		end else if (ce) begin
			if (in_valid && in_ready) begin
				wr_ptr <= ~wr_ptr;
			end
			if (out_valid && out_ready) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
		end
	end
endmodule // dbsi_buf2

module dbsi_imp_cal (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic cmp_hi,
	output logic [`DBSI_CODE_W-1:0] code
);
	// One step per evaluation, saturating at both ends
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			code <= `DBSI_CODE_RESET;
		end else if (ce && tick) begin
			if (cmp_hi && code != `DBSI_CODE_MAX) begin
				code <= code + 4'h1;
			end else if (!cmp_hi && code != `DBSI_CODE_MIN) begin
				code <= code - 4'h1;
			end
		end
	end
endmodule // dbsi_imp_cal

module dbsi_sram
	import dbsi_pkg::*;
#(
	parameter int DQ_W = 18,
	parameter int LANE_W = 9,
	parameter int ADDR_W = 22,
	parameter int CAL_CYCLES = `DBSI_CAL_CYCLES
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic k_clk,
	input wire logic k_clk_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic command_load_n,
	input wire logic read_select,
	input wire logic [DQ_W/LANE_W-1:0] byte_write_enable_n,
	input wire logic [DQ_W-1:0] dq_i,
	output logic [DQ_W-1:0] dq_o,
	output logic dq_oe,
	input wire logic termination_select,
	input wire logic impedance_ref_pin,
	input wire logic term_cmp_hi,
	output logic term_strong,
	output logic term_active,
	output logic [`DBSI_CODE_W-1:0] drive_code,
	output logic [`DBSI_CODE_W-1:0] term_code,
	output logic deselected
);
	localparam int NL = DQ_W / LANE_W;
	localparam int SW = 7 + ADDR_W + NL + DQ_W;

	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic k_prev;
	logic kn_prev;
	logic k_s;
	logic kn_s;
	logic [ADDR_W-1:0] addr_s;
	logic ld_n_s;
	logic rd_s;
	logic [NL-1:0] bwe_n_s;
	logic [DQ_W-1:0] d_s;
	logic sel_s;
	logic zq_s;
	logic tcmp_s;
	logic k_rise;
	logic kn_rise;

	// Pin inputs pass two flops; all share the same delay so alignment holds
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (ce) begin
			sync1 <= {k_clk, k_clk_n, command_load_n, read_select, termination_select,
				impedance_ref_pin, term_cmp_hi, address, byte_write_enable_n, dq_i};
			sync2 <= sync1;
		end
	end

	assign {k_s, kn_s, ld_n_s, rd_s, sel_s, zq_s, tcmp_s, addr_s, bwe_n_s, d_s} = sync2;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			k_prev <= 1'b0;
			kn_prev <= 1'b0;
		end else if (ce) begin
			k_prev <= k_s;
			kn_prev <= kn_s;
		end
	end

	assign k_rise = k_s && !k_prev;
	assign kn_rise = kn_s && !kn_prev;

	logic [2*DQ_W-1:0] mem [0:2**ADDR_W-1];
	dbsi_cmd_t p1;
	dbsi_cmd_t p2;
	dbsi_cmd_t next_cmd;
	logic [ADDR_W-1:0] a1;
	logic [ADDR_W-1:0] wr_addr;
	logic wr_arm;
	logic [DQ_W-1:0] d1;
	logic [NL-1:0] m1;
	logic [2*DQ_W-1:0] rd_word;
	logic rd_push;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [2*DQ_W-1:0] buf_out;
	logic pop;
	logic [DQ_W-1:0] beat1;
	logic read_slot;

	always_comb begin
		next_cmd = DBSI_NOP;
		if (!ld_n_s && rd_s && buf_in_ready) begin
			next_cmd = DBSI_READ;
		end else if (!ld_n_s && !rd_s) begin
			next_cmd = DBSI_WRITE;
		end
	end

	// Command pipeline: deselects travel the same depth as reads
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			p1 <= DBSI_NOP;
			p2 <= DBSI_NOP;
			a1 <= '0;
		end else if (ce && k_rise) begin
			p1 <= next_cmd;
			p2 <= p1;
			a1 <= addr_s;
		end
	end

	// Array read of the double-width word at the base address
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_word <= '0;
			rd_push <= 1'b0;
		end else if (ce) begin
			rd_push <= k_rise && next_cmd == DBSI_READ;
			if (k_rise && next_cmd == DBSI_READ) begin
				rd_word <= mem[addr_s];
			end
		end
	end

	assign pop = ce && k_rise && p2 == DBSI_READ;

	dbsi_buf2 #(.W(2*DQ_W)) u_rd_buf (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ce(ce),
		.in_valid(rd_push),
		.in_ready(buf_in_ready),
		.in_data(rd_word),
		.out_valid(buf_out_valid),
		.out_ready(pop),
		.out_data(buf_out)
	);

	// Output beats: first at K edge n+2, second at following K-bar edge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dq_o <= '0;
			dq_oe <= 1'b0;
			beat1 <= '0;
			read_slot <= 1'b0;
		end else if (ce) begin
			if (k_rise) begin
				read_slot <= p2 == DBSI_READ;
				dq_oe <= p2 == DBSI_READ && buf_out_valid;
				if (p2 == DBSI_READ) begin
					dq_o <= buf_out[DQ_W-1:0];
					beat1 <= buf_out[2*DQ_W-1:DQ_W];
				end
			end else if (kn_rise && read_slot) begin
				dq_o <= beat1;
			end
		end
	end

	// Late write: beat one at K edge n+1, beat two at next K-bar edge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_arm <= 1'b0;
			wr_addr <= '0;
			d1 <= '0;
			m1 <= '0;
		end else if (ce) begin
			if (k_rise && p1 == DBSI_WRITE) begin
				wr_arm <= 1'b1;
				wr_addr <= a1;
				d1 <= d_s;
				m1 <= bwe_n_s;
			end else if (kn_rise && wr_arm) begin
				wr_arm <= 1'b0;
			end
		end
	end

	// Per-lane commit; narrow lanes give nybble masking with lane 0 lowest
	always_ff @(posedge ref_clk) begin
		if (ce && kn_rise && wr_arm) begin
			for (int i = 0; i < NL; i++) begin
				if (!m1[i]) begin
					mem[wr_addr][i*LANE_W +: LANE_W] <= d1[i*LANE_W +: LANE_W];
				end
				if (!bwe_n_s[i]) begin
					mem[wr_addr][DQ_W + i*LANE_W +: LANE_W] <= d_s[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	assign deselected = p1 == DBSI_NOP && p2 == DBSI_NOP && !dq_oe && !wr_arm;

	// Termination: always on, range from the select pin
	assign term_strong = !sel_s;
	assign term_active = 1'b1;

	logic [`DBSI_CAL_CNT_W-1:0] cal_cnt;
	logic cal_tick;

	assign cal_tick = cal_cnt == `DBSI_CAL_CNT_W'(CAL_CYCLES - 1);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cal_cnt <= '0;
		end else if (ce) begin
			cal_cnt <= cal_tick ? '0 : cal_cnt + 1'b1;
		end
	end

	dbsi_imp_cal u_drv_cal (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ce(ce),
		.tick(cal_tick),
		.cmp_hi(zq_s),
		.code(drive_code)
	);

	dbsi_imp_cal u_term_cal (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ce(ce),
		.tick(cal_tick),
		.cmp_hi(tcmp_s),
		.code(term_code)
	);

	default clocking dbsi_cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	chk_read_drives: assert property (ce && k_rise && p2 == DBSI_READ && buf_out_valid |=> dq_oe)
		else $error("Read slot did not enable drivers");
	chk_nonread_release: assert property (ce && k_rise && p2 != DBSI_READ |=> !dq_oe)
		else $error("Drivers left on in a non-read slot");
	chk_deselect_after_read: assert property (ce && k_rise && read_slot && p2 == DBSI_NOP |-> dq_oe ##1 !dq_oe)
		else $error("Deselect after read kept drivers on");
	chk_load_high_nop: assert property (ce && k_rise && ld_n_s |=> p1 == DBSI_NOP)
		else $error("Command taken with load high");
	chk_read_capture: assert property (ce && k_rise && !ld_n_s && rd_s && buf_in_ready |=> p1 == DBSI_READ)
		else $error("Read not captured");
	chk_write_arm: assert property (ce && k_rise && p1 == DBSI_WRITE |=> wr_arm && wr_addr == $past(a1))
		else $error("Write beat one not captured");
	chk_second_beat: assert property (ce && kn_rise && read_slot && !k_rise |=> dq_o == $past(beat1))
		else $error("Second read beat missing");
	chk_cal_restart: assert property (ce && cal_tick |=> cal_cnt == '0)
		else $error("Calibration counter did not restart");
	chk_drive_step: assert property (drive_code != $past(drive_code) |->
		(drive_code == $past(drive_code) + 4'h1 || drive_code == $past(drive_code) - 4'h1))
		else $error("Driver code moved more than one step");
	chk_term_step: assert property (term_code != $past(term_code) |-> $past(cal_tick))
		else $error("Termination code moved off schedule");
	chk_term_range: assert property ($rose(sel_s) |-> !term_strong ##1 $stable(term_strong) || $changed(sel_s))
		else $error("Termination range not following select");

	cov_read: cover property (ce && k_rise && p2 == DBSI_READ ##1 dq_oe);
	cov_masked_write: cover property (ce && kn_rise && wr_arm && m1 != '0 && m1 != '1);
	cov_deselect: cover property ($rose(deselected));
	cov_cal_step: cover property (ce && cal_tick && drive_code != `DBSI_CODE_MAX);
endmodule // dbsi_sram
`default_nettype wire

// ==== dbsi_ctrl_model.sv ====
// Memory controller model driving K, K-bar, command, address and write data
`timescale 1ns/1ps
`default_nettype none
module dbsi_ctrl_model (
	input wire logic ref_clk,
	input wire logic [17:0] dq_pin,
	input wire logic dq_oe,
	output logic k_clk,
	output logic k_clk_n,
	output logic [5:0] address,
	output logic command_load_n,
	output logic read_select,
	output logic [1:0] byte_write_enable_n,
	output logic [17:0] dq_drv
);
	initial begin
		k_clk = 1'b0;
		k_clk_n = 1'b0;
		address = 6'h00;
		command_load_n = 1'b1;
		read_select = 1'b0;
		byte_write_enable_n = 2'h3;
		dq_drv = 18'h0_0000;
	end
	// One K period of 16 ref_clk cycles, entered at a falling edge
	task automatic kcyc(input logic ld_n, input logic rs, input logic [5:0] a, input logic [17:0] d0,
		input logic [1:0] m0, input logic [17:0] d1, input logic [1:0] m1,
		output logic [17:0] q0, output logic [17:0] q1, output logic oe0, output logic oe1);
		k_clk = 1'b1;
		k_clk_n = 1'b0;
		command_load_n = ld_n;
		read_select = rs;
		address = a;
		dq_drv = d0;
		byte_write_enable_n = m0;
		repeat (7) @(negedge ref_clk);
		q0 = dq_pin;
		oe0 = dq_oe;
		@(negedge ref_clk);
		k_clk = 1'b0;
		k_clk_n = 1'b1;
		// Address hold has run out, so the lines no longer show it
		address = ~a;
		read_select = ~rs;
		dq_drv = d1;
		byte_write_enable_n = m1;
		repeat (7) @(negedge ref_clk);
		q1 = dq_pin;
		oe1 = dq_oe;
		@(negedge ref_clk);
	endtask
endmodule // dbsi_ctrl_model
`default_nettype wire

// ==== dbsi_sram_test.sv ====
// Self-checking testbench for the burst-of-two SRAM core
`timescale 1ns/1ps
`default_nettype none
module dbsi_sram_test;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic termination_select = 1'b1;
	logic impedance_ref_pin = 1'b1;
	logic term_cmp_hi = 1'b0;
	logic k_clk, k_clk_n, command_load_n, read_select, dq_oe, term_strong, term_active, deselected, oe0, oe1;
	logic [5:0] address;
	logic [1:0] byte_write_enable_n;
	logic [17:0] dq_o, dq_drv, q0, q1;
	logic [3:0] drive_code, term_code;
	wire [17:0] dq_pin;
	int err_count = 0;
	int cmp_count = 0;
	// Pin level: device when it drives, controller otherwise
	assign dq_pin = dq_oe ? dq_o : dq_drv;
	always #5 ref_clk = ~ref_clk;
	dbsi_sram #(.DQ_W(18), .LANE_W(9), .ADDR_W(6), .CAL_CYCLES(8)) dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .k_clk(k_clk), .k_clk_n(k_clk_n),
		.address(address), .command_load_n(command_load_n), .read_select(read_select),
		.byte_write_enable_n(byte_write_enable_n), .dq_i(dq_pin), .dq_o(dq_o), .dq_oe(dq_oe),
		.termination_select(termination_select), .impedance_ref_pin(impedance_ref_pin),
		.term_cmp_hi(term_cmp_hi), .term_strong(term_strong), .term_active(term_active),
		.drive_code(drive_code), .term_code(term_code), .deselected(deselected)
	);
	dbsi_ctrl_model ctl (
		.ref_clk(ref_clk), .dq_pin(dq_pin), .dq_oe(dq_oe), .k_clk(k_clk), .k_clk_n(k_clk_n),
		.address(address), .command_load_n(command_load_n), .read_select(read_select),
		.byte_write_enable_n(byte_write_enable_n), .dq_drv(dq_drv)
	);
	localparam logic [17:0] A0 = 18'h1_2345;
	localparam logic [17:0] A1 = 18'h2_6789;
	localparam logic [17:0] B0 = 18'h3_0F0F;
	localparam logic [17:0] B1 = 18'h0_F0F0;
	localparam logic [17:0] E0 = {A0[17:9], B0[8:0]};
	localparam logic [17:0] E1 = {B1[17:9], A1[8:0]};
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic kc(input logic ld_n, input logic rs, input logic [5:0] a, input logic [17:0] d0,
		input logic [1:0] m0, input logic [17:0] d1, input logic [1:0] m1);
		ctl.kcyc(ld_n, rs, a, d0, m0, d1, m1, q0, q1, oe0, oe1);
	endtask
	task automatic test_masked_write();
		kc(1'b0, 1'b0, 6'h04, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		kc(1'b0, 1'b0, 6'h04, A0, 2'h0, A1, 2'h0);
		kc(1'b1, 1'b0, 6'h00, B0, 2'h2, B1, 2'h1);
		check(18'({oe0, oe1}), 18'h0);
		kc(1'b0, 1'b1, 6'h04, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		kc(1'b1, 1'b0, 6'h00, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(18'({oe0, oe1}), 18'h0);
		kc(1'b1, 1'b0, 6'h00, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(18'({oe0, oe1}), 18'h3);
		check(q0, E0);
		check(q1, E1);
		kc(1'b1, 1'b0, 6'h00, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(18'({oe0, oe1}), 18'h0);
		check(18'(deselected), 18'h1);
		$display("test_masked_write done");
	endtask
	task automatic test_read_stream();
		kc(1'b0, 1'b1, 6'h04, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		kc(1'b1, 1'b1, 6'h04, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		kc(1'b0, 1'b1, 6'h04, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(18'({oe0, oe1}), 18'h3);
		check(q0, E0);
		kc(1'b0, 1'b1, 6'h04, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(18'({oe0, oe1}), 18'h0);
		kc(1'b1, 1'b0, 6'h00, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(q0, E0);
		kc(1'b1, 1'b0, 6'h00, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(q1, E1);
		check({q0[8:0], q1[8:0], oe0, oe1} == {E0[8:0], E1[8:0], 2'h3} ? 18'h1 : 18'h0, 18'h1);
		kc(1'b1, 1'b0, 6'h00, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(18'({oe0, oe1}), 18'h0);
		kc(1'b1, 1'b0, 6'h00, 18'h0_0000, 2'h3, 18'h0_0000, 2'h3);
		check(18'({oe0, oe1, deselected}), 18'h1);
		$display("test_read_stream done");
	endtask
	task automatic test_calibration();
		check(18'(drive_code), 18'h0_000F);
		check(18'(term_code), 18'h0_0000);
		impedance_ref_pin = 1'b0;
		term_cmp_hi = 1'b1;
		for (int i = 0; i < 20 && drive_code === 4'hF; i++) @(negedge ref_clk);
		check(18'({drive_code, term_code}), 18'h0_00E1);
		repeat (7) @(negedge ref_clk);
		check(18'({drive_code, term_code}), 18'h0_00E1);
		@(negedge ref_clk);
		check(18'({drive_code, term_code}), 18'h0_00D2);
		$display("test_calibration done");
	endtask
	task automatic test_termination();
		termination_select = 1'b0;
		repeat (4) @(negedge ref_clk);
		check(18'({term_strong, term_active}), 18'h3);
		termination_select = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(18'({term_strong, term_active}), 18'h1);
		$display("test_termination done");
	endtask
	task automatic close_out();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		test_masked_write();
		test_read_stream();
		test_calibration();
		test_termination();
		close_out();
	end
	// Tests take about 280 ref_clk cycles; allow about fourteen times that
	initial begin
		repeat (4000) @(posedge ref_clk);
		err_count++;
		close_out();
	end
endmodule // dbsi_sram_test
`default_nettype wire
